/* File: hw/port_cfg_pkg.sv */
// Purpose: Shared constants and types for the port configuration message handler
// Assumes: 125 MHz core clock, two ports per node, APB register access
// Notes:   Message bytes sit big-endian in the message words (byte 0 at bit 127)
package port_cfg_pkg;

	// ------------------------------------------------------------------
	// Register byte offsets
	// ------------------------------------------------------------------
	localparam logic [7:0] OFF_MSG0   = 8'h00;	// Message bytes 0..3
	localparam logic [7:0] OFF_MSG1   = 8'h04;	// Message bytes 4..7
	localparam logic [7:0] OFF_MSG2   = 8'h08;	// Message bytes 8..11
	localparam logic [7:0] OFF_MSG3   = 8'h0C;	// Message bytes 12..15
	localparam logic [7:0] OFF_CTRL   = 8'h10;	// Go and arrival port
	localparam logic [7:0] OFF_RESP   = 8'h14;	// Last response
	localparam logic [7:0] OFF_STAT   = 8'h18;	// Queue and reply status
	localparam logic [7:0] OFF_PORT0  = 8'h1C;	// Port 0 settings readback
	localparam logic [7:0] OFF_PORT1  = 8'h20;	// Port 1 settings readback
	localparam logic [7:0] OFF_ENQ    = 8'h24;	// Software alert enqueue

	// ------------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------------
	localparam int CTRL_GO_BIT    = 0;	// Write one to process message
	localparam int CTRL_PORT_BIT  = 1;	// Port the message arrived on
	localparam int CTL_USER_BIT   = 7;	// User character enable
	localparam int CTL_REFL_BIT   = 6;	// Reflect control
	localparam int CTL_MODE_LSB   = 4;	// Two-bit mode field
	localparam int CTL_EXT_BIT    = 1;	// Extended distance enable
	localparam int CTL_REDUCED_ACK_TIMEOUT_BIT   = 0;	// Reduced ack time-out
	localparam int ENT_PORT_BIT   = 24;	// Queue entry source port

	// ------------------------------------------------------------------
	// Message and return codes
	// ------------------------------------------------------------------
	localparam logic [7:0]  MSG_CFG      = 8'h02;	// Port configuration
	localparam logic [7:0]  MSG_REPLY    = 8'h07;	// Alert acknowledgement
	localparam logic [7:0]  RC_OK        = 8'h00;	// Success
	localparam logic [7:0]  RC_INVALID   = 8'hFF;	// Invalid field
	localparam logic [23:0] ALERT_ALARM  = 24'h1A0000;	// Alarm threshold exceeded

	// Port modes
	localparam logic [1:0] MODE_KEEP   = 2'h0;
	localparam logic [1:0] MODE_WRAP   = 2'h1;
	localparam logic [1:0] MODE_NORMAL = 2'h2;
	localparam logic [1:0] MODE_PRIV   = 2'h3;

	// ------------------------------------------------------------------
	// Timing and reset values
	// ------------------------------------------------------------------
	localparam int CLK_MHZ        = 125;	// Core clock rate
	localparam int ACK_SHORT_US   = 25;	// Short ack time-out, least value
	localparam int ACK_LONG_US    = 100;	// Long ack time-out, least value
	localparam logic [15:0] ACK_SHORT_CYC = 16'(ACK_SHORT_US * CLK_MHZ);
	localparam int NUM_PORTS      = 2;	// Ports per node
	localparam logic [1:0]  RST_MODE  = MODE_NORMAL;
	localparam logic [7:0]  RST_QUOTA = 8'h01;

	// Handler states, one-hot
	typedef enum logic [2:0] {
		ST_IDLE  = 3'b001,
		ST_DRAIN = 3'b010,
		ST_RESP  = 3'b100
	} cfg_state_t;

endpackage

/* File: hw/port_cfg_handler.sv */
// Purpose: Decode alert acknowledgements and port configuration messages
// Assumes: Software loads a whole message over APB, then writes go
// Notes:   One message in flight; go while busy is ignored
//
// What this block does
// - Reply return code 00h ok, FFh invalid
// - Alert tag kept until new configuration tag
// - Discard reply whose alert code differs
// - Matching reply dequeues head alert entry
// - Code 02h configures port, always answered
// - Store path and tag, answer on arrival port
// - Second quota below first: reject all, invalid
// - User character enable gates user characters
// - Reflect bit sets dual-port reflection flag; clear bit clears it only with both ports operational
// - Mode field: keep, wrap, normal, privileged
// - Mode keep: send pending alerts before response
// - Wrap only via other port; wrap non-operational
// - Privileged via other port leaves wrap
// - Normal requested while in wrap is invalid
// - Extended distance unsupported gives invalid field
// - Extended distance selects long ack time-out
// - Reduced ack bit forces short time-out
// - Alarm alert once when counter equals threshold
// - Clear-link-error query zeroes error counter
// - Two flags choose offered negotiation speeds
// - Both flags clear leaves negotiation unchanged
// - Latest configuration replaces earlier parameters
// - Slow dual-speed port alerts after response
`timescale 1ns/1ps
`default_nettype none

module port_cfg_handler
	import port_cfg_pkg::*;
#(
	parameter int          QDEPTH        = 4,	// Queued alert table depth
	parameter logic [1:0]  EXT_DIST_PORTS = 2'b11,	// Ports with extended distance
	parameter bit          DUAL_PORT     = 1'b1,	// Node is dual port
	parameter logic [23:0] ALERT_SLOW    = 24'h200000,	// Slow speed alert code
	parameter logic [15:0] ACK_LONG_CYC  = 16'(ACK_LONG_US * CLK_MHZ)
) (
	input  wire logic                 core_clk,
	input  wire logic                 srst,
	// APB slave
	input  wire logic                 psel,
	input  wire logic                 penable,
	input  wire logic                 pwrite,
	input  wire logic [7:0]           paddr,
	input  wire logic [31:0]          pwdata,
	output logic                      pready,
	output logic [31:0]               prdata,
	output logic                      pslverr,
	// Port status from the link layer
	input  wire logic [1:0]           port_operational,
	input  wire logic [1:0]           erp_invoke,
	input  wire logic [1:0]           query_clear_err,
	input  wire logic [1:0]           dual_speed_capable,
	input  wire logic [1:0]           running_low_speed,
	// Response message out
	output logic                      resp_valid,
	output logic [7:0]                resp_code,
	output logic [15:0]               resp_tag,
	output logic                      resp_port,
	output logic [31:0]               ret_path,
	// Alert message out
	output logic                      alert_valid,
	output logic [23:0]               alert_code,
	output logic [15:0]               alert_tag,
	output logic                      alert_src_port,
	output logic                      alert_tx_port,
	// Port settings
	output logic [1:0][1:0]           port_mode,
	output logic [1:0]                user_char_enable,
	output logic [1:0]                extended_distance_on,
	output logic [1:0][15:0]          ack_limit,
	output logic [1:0][1:0]           negotiate_speed,
	output logic [1:0][7:0]           a_quota,
	output logic [1:0][7:0]           b_quota,
	output logic                      reflection_flag,
	output logic [1:0]                begin_comm
);

	localparam int QCW = $clog2(QDEPTH + 1);	// Queue count width

	// ------------------------------------------------------------------
	// State record
	// ------------------------------------------------------------------
	typedef struct packed {
		cfg_state_t             st;	// Handler state
		logic [127:0]           msg;	// Message bytes 0..15
		logic                   rx_port;	// Arrival port
		logic                   cfg_port;	// Port being configured
		logic [1:0][7:0]        aq;	// First frame quota
		logic [1:0][7:0]        bq;	// Per-rotation quota
		logic [1:0]             user;	// User characters allowed
		logic [1:0]             ext;	// Extended distance on
		logic [1:0][1:0]        mode;	// Port mode
		logic [1:0][15:0]       ack;	// Ack time-out in cycles
		logic [1:0][15:0]       thr;	// Alarm threshold
		logic [1:0][15:0]       error_recovery_procedure;	// Error recovery count
		logic [1:0][1:0]        neg;	// Negotiation flags
		logic                   refl;	// Reflection flag
		logic [15:0]            atag;	// Alert tag
		logic [31:0]            path;	// Return path
		logic                   txp;	// Port for alerts
		logic [QDEPTH-1:0][24:0] q;	// Queued alerts, head at 0
		logic [QCW-1:0]         qcnt;	// Entries in queue
		logic [QCW-1:0]         idx;	// Drain walk index
		logic                   head_sent;	// Head already sent
		logic [1:0]             alarm_pend;	// Alarm waiting for queue
		logic [1:0]             slow_pend;	// Slow alert waiting
		logic                   sw_pend;	// Software alert waiting
		logic [24:0]            sw_ent;	// Software alert entry
		logic                   rv;	// Response pulse
		logic [7:0]             rcode;	// Response code
		logic [15:0]            rtag;	// Response tag
		logic                   rport;	// Response port
		logic                   av;	// Alert pulse
		logic [24:0]            aent;	// Alert entry sent
		logic [1:0]             bc;	// Beginning communication pulse
		logic [7:0]             reply_rc;	// Last reply return code
		logic [7:0]             drops;	// Dropped replies
		logic [31:0]            rdata;	// APB read data
	} state_t;

	state_t r_r;	// Registered state
	state_t r_nxt;	// Next state

	// Message fields
	logic [7:0]  m_code;	// Message code
	logic [7:0]  m_port;	// Port field
	logic [15:0] m_tag;	// Tag field
	logic [7:0]  m_ctl;	// Control byte
	logic [23:0] m_acode;	// Alert code in a reply

	assign m_code  = r_r.msg[127:120];
	assign m_port  = r_r.msg[119:112];
	assign m_tag   = r_r.msg[111:96];
	assign m_acode = r_r.msg[95:72];
	assign m_ctl   = r_r.msg[39:32];

	logic        go;	// Accepted go write
	logic        rxp;	// Arrival port, this go write included
	logic        deq;	// Remove head entry
	logic        inv;	// Configuration invalid
	logic        pend_hit;	// Pending alert for port
	logic        p;	// Configured port index
	logic [1:0]  mfld;	// Mode field
	logic [24:0] ent;	// Entry to enqueue
	logic        enq;	// Enqueue request
	logic [15:0] cnt_inc;	// Incremented error count

	// ------------------------------------------------------------------
	// Next-state logic
	// ------------------------------------------------------------------
	always_comb begin
		r_nxt    = r_r;
		go       = 1'b0;
		rxp      = r_r.rx_port;
		deq      = 1'b0;
		inv      = 1'b0;
		pend_hit = 1'b0;
		p        = m_port[0];
		mfld     = m_ctl[CTL_MODE_LSB +: 2];
		ent      = '0;
		enq      = 1'b0;
		cnt_inc  = '0;
		r_nxt.rv = 1'b0;
		r_nxt.av = 1'b0;
		r_nxt.bc = '0;

		// Register writes at the access phase
		if (psel && penable && pwrite) begin
			unique case (paddr)
				OFF_MSG0: r_nxt.msg[127:96] = pwdata;
				OFF_MSG1: r_nxt.msg[95:64]  = pwdata;
				OFF_MSG2: r_nxt.msg[63:32]  = pwdata;
				OFF_MSG3: r_nxt.msg[31:0]   = pwdata;
				OFF_CTRL: begin
					// Busy handler ignores go and keeps its arrival port
					if (r_r.st == ST_IDLE) begin
						go            = pwdata[CTRL_GO_BIT];
						r_nxt.rx_port = pwdata[CTRL_PORT_BIT];
						// Go and port share one write, so decode with the new port
						rxp           = pwdata[CTRL_PORT_BIT];
					end
				end
				OFF_ENQ: begin
					if (!r_r.sw_pend) begin
						r_nxt.sw_pend = 1'b1;
						r_nxt.sw_ent  = pwdata[24:0];
					end
				end
				default: ;
			endcase
		end

		// Read data captured in the setup phase
		if (psel && !penable) begin
			unique case (paddr)
				OFF_MSG0:  r_nxt.rdata = r_r.msg[127:96];
				OFF_MSG1:  r_nxt.rdata = r_r.msg[95:64];
				OFF_MSG2:  r_nxt.rdata = r_r.msg[63:32];
				OFF_MSG3:  r_nxt.rdata = r_r.msg[31:0];
				OFF_CTRL:  r_nxt.rdata = {30'h0, r_r.rx_port, r_r.st != ST_IDLE};
				OFF_RESP:  r_nxt.rdata = {r_r.rtag, r_r.rcode, 7'h0, r_r.rport};
				OFF_STAT:  r_nxt.rdata = {8'h0, r_r.drops, r_r.reply_rc, 8'(r_r.qcnt)};
				OFF_PORT0: r_nxt.rdata = {r_r.thr[0], 8'h0, r_r.neg[0], r_r.mode[0],
					r_r.refl, r_r.ext[0], r_r.user[0], 1'b0};
				OFF_PORT1: r_nxt.rdata = {r_r.thr[1], 8'h0, r_r.neg[1], r_r.mode[1],
					r_r.refl, r_r.ext[1], r_r.user[1], 1'b0};
				default:   r_nxt.rdata = 32'h0;
			endcase
		end

		// Pending alerts on the configured port
		for (int i = 0; i < QDEPTH; i++) begin
			if (QCW'(i) < r_r.qcnt && r_r.q[i][ENT_PORT_BIT] == p) begin
				pend_hit = 1'b1;
			end
		end

		// Message handling
		unique case (r_r.st)
			ST_IDLE: begin
				if (go && m_code == MSG_REPLY) begin
					r_nxt.reply_rc = r_r.msg[119:112];
					// Type, subtype and information must match the head
					if (r_r.qcnt != '0 && m_acode == r_r.q[0][23:0]
						&& m_tag == r_r.atag) begin
						deq = 1'b1;
					end else begin
						r_nxt.drops = r_r.drops + 8'h01;
					end
				end else if (go && m_code == MSG_CFG) begin
					// Any bad field rejects the whole message
					inv = (r_r.msg[47:40] < r_r.msg[55:48])
						|| (m_ctl[CTL_EXT_BIT] && !EXT_DIST_PORTS[p])
						|| (m_port >= 8'(NUM_PORTS))
						|| (mfld == MODE_WRAP && p == rxp)
						|| (mfld == MODE_NORMAL && r_r.mode[p] == MODE_WRAP);
					r_nxt.cfg_port = p;
					r_nxt.rtag     = m_tag;
					r_nxt.rport    = rxp;
					r_nxt.rcode    = inv ? RC_INVALID : RC_OK;
					if (!inv) begin
						// Latest message replaces stored values, except mode on keep, negotiation on clear flags, reflection
						r_nxt.atag    = m_tag;
						r_nxt.path    = r_r.msg[95:64];
						r_nxt.txp     = rxp;
						r_nxt.aq[p]   = r_r.msg[55:48];
						r_nxt.bq[p]   = r_r.msg[47:40];
						r_nxt.user[p] = m_ctl[CTL_USER_BIT];
						if (DUAL_PORT) begin
							if (m_ctl[CTL_REFL_BIT]) begin
								r_nxt.refl = 1'b1;
							end else if (&port_operational) begin
								r_nxt.refl = 1'b0;
							end
						end
						if (mfld != MODE_KEEP) begin
							r_nxt.mode[p] = mfld;
						end
						// Privileged from the other port leaves wrap
						if (mfld == MODE_PRIV && r_r.mode[p] == MODE_WRAP
							&& p != rxp) begin
							r_nxt.bc[p] = 1'b1;
						end
						r_nxt.ext[p] = m_ctl[CTL_EXT_BIT];
						// Reduced ack overrides the long window
						r_nxt.ack[p] = (m_ctl[CTL_EXT_BIT] && !m_ctl[CTL_REDUCED_ACK_TIMEOUT_BIT])
							? ACK_LONG_CYC : ACK_SHORT_CYC;
						r_nxt.thr[p] = r_r.msg[23:8];
						if (r_r.msg[1:0] != 2'b00) begin
							r_nxt.neg[p] = r_r.msg[1:0];
						end
					end
					r_nxt.idx = '0;
					r_nxt.st  = (mfld == MODE_KEEP && pend_hit) ? ST_DRAIN : ST_RESP;
				end else if (!go && r_r.qcnt != '0 && !r_r.head_sent) begin
					// Outstanding alert goes out once until acknowledged
					r_nxt.av        = 1'b1;
					r_nxt.aent      = r_r.q[0];
					r_nxt.head_sent = 1'b1;
				end
			end
			ST_DRAIN: begin
				// Walk the queue, sending entries for the configured port
				if (r_r.idx < r_r.qcnt) begin
					if (r_r.q[r_r.idx][ENT_PORT_BIT] == r_r.cfg_port) begin
						r_nxt.av   = 1'b1;
						r_nxt.aent = r_r.q[r_r.idx];
					end
					r_nxt.idx = r_r.idx + QCW'(1);
				end else begin
					r_nxt.st = ST_RESP;
				end
			end
			ST_RESP: begin
				r_nxt.rv = 1'b1;
				r_nxt.st = ST_IDLE;
				if (dual_speed_capable[r_r.cfg_port] && running_low_speed[r_r.cfg_port]) begin
					r_nxt.slow_pend[r_r.cfg_port] = 1'b1;
				end
			end
			default: r_nxt.st = ST_IDLE;
		endcase

		// Queue: remove head, then add one pending alert
		if (deq) begin
			for (int i = 0; i < QDEPTH - 1; i++) begin
				r_nxt.q[i] = r_r.q[i + 1];
			end
			r_nxt.qcnt      = r_r.qcnt - QCW'(1);
			r_nxt.head_sent = 1'b0;
		end
		if (r_r.sw_pend) begin
			ent = r_r.sw_ent;
			enq = 1'b1;
		end else if (r_r.alarm_pend[0] || r_r.alarm_pend[1]) begin
			ent = {!r_r.alarm_pend[0], ALERT_ALARM};
			enq = 1'b1;
		end else if (r_r.slow_pend[0] || r_r.slow_pend[1]) begin
			ent = {!r_r.slow_pend[0], ALERT_SLOW};
			enq = 1'b1;
		end
		// A full queue holds the alert pending until room appears
		if (enq && r_nxt.qcnt < QCW'(QDEPTH)) begin
			r_nxt.q[r_nxt.qcnt] = ent;
			r_nxt.qcnt = r_nxt.qcnt + QCW'(1);
			if (r_r.sw_pend) begin
				r_nxt.sw_pend = 1'b0;
			end else if (r_r.alarm_pend != 2'b00) begin
				r_nxt.alarm_pend[ent[ENT_PORT_BIT]] = 1'b0;
			end else begin
				r_nxt.slow_pend[ent[ENT_PORT_BIT]] = 1'b0;
			end
		end

		// Error recovery counters; clear wins over a count-up in the same cycle, and no alarm is set
		for (int k = 0; k < NUM_PORTS; k++) begin
			cnt_inc = (r_r.error_recovery_procedure[k] == 16'hFFFF) ? r_r.error_recovery_procedure[k] : r_r.error_recovery_procedure[k] + 16'h0001;
			if (query_clear_err[k]) begin
				r_nxt.error_recovery_procedure[k] = 16'h0000;
			end else if (erp_invoke[k]) begin
				r_nxt.error_recovery_procedure[k] = cnt_inc;
				// Equality happens only once per count-up, so one alert
				if (r_r.thr[k] != 16'h0000 && cnt_inc == r_r.thr[k]
					&& cnt_inc != r_r.error_recovery_procedure[k]) begin
					r_nxt.alarm_pend[k] = 1'b1;
				end
			end
		end
	end

	// ------------------------------------------------------------------
	// State register
	// ------------------------------------------------------------------
	always_ff @(posedge core_clk) begin
		if (srst) begin
			r_r      <= '0;
			r_r.st   <= ST_IDLE;
			r_r.mode <= {RST_MODE, RST_MODE};
			r_r.aq   <= {RST_QUOTA, RST_QUOTA};
			r_r.bq   <= {RST_QUOTA, RST_QUOTA};
			r_r.ack  <= {ACK_SHORT_CYC, ACK_SHORT_CYC};
		end else begin
			r_r <= r_nxt;
		end
	end

	// ------------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------------
	assign pready  = 1'b1;	// Zero wait states
	assign pslverr = psel && penable && (paddr[1:0] != 2'b00 || paddr > OFF_ENQ);
	assign prdata  = r_r.rdata;
	assign resp_valid = r_r.rv;
	assign resp_code  = r_r.rcode;
	assign resp_tag   = r_r.rtag;
	assign resp_port  = r_r.rport;
	assign ret_path   = r_r.path;
	assign alert_valid    = r_r.av;
	assign alert_code     = r_r.aent[23:0];
	assign alert_tag      = r_r.atag;
	assign alert_src_port = r_r.aent[ENT_PORT_BIT];
	assign alert_tx_port  = r_r.txp;
	assign port_mode            = r_r.mode;
	assign user_char_enable     = r_r.user;
	assign extended_distance_on = r_r.ext;
	assign ack_limit            = r_r.ack;
	assign negotiate_speed      = r_r.neg;
	assign a_quota              = r_r.aq;
	assign b_quota              = r_r.bq;
	assign reflection_flag      = r_r.refl;
	assign begin_comm           = r_r.bc;

	// ------------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------------
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (srst);

	a_resp_code_legal: assert property (resp_valid |-> (resp_code == RC_OK || resp_code == RC_INVALID))
		else $error("response code not ok or invalid");
	a_quota_reject: assert property ((go && m_code == MSG_CFG && r_r.msg[47:40] < r_r.msg[55:48])
		|=> ##[0:8] (resp_valid && resp_code == RC_INVALID))
		else $error("quota violation not answered invalid");
	a_resp_on_port: assert property ((go && m_code == MSG_CFG) |=> ##[0:8] (resp_valid
		&& resp_port == $past(r_r.rx_port, 1)))
		else $error("response missing or on wrong port");
	a_wrap_same_port: assert property ((go && m_code == MSG_CFG && mfld == MODE_WRAP
		&& p == rxp) |=> $stable(r_r.mode))
		else $error("wrap via same port changed mode");
	a_alarm_arm: assert property ((erp_invoke[0] && !query_clear_err[0] && r_r.thr[0] != 16'h0000
		&& r_r.error_recovery_procedure[0] + 16'h0001 == r_r.thr[0]) |=> r_r.alarm_pend[0])
		else $error("alarm not raised at threshold");
	a_clear_count: assert property (query_clear_err[0] |=> r_r.error_recovery_procedure[0] == 16'h0000)
		else $error("error counter not cleared");
	a_reduced_ack_timeout_short: assert property ((go && m_code == MSG_CFG && !inv && !p && m_ctl[CTL_REDUCED_ACK_TIMEOUT_BIT])
		|=> ack_limit[0] == ACK_SHORT_CYC)
		else $error("reduced ack did not force short time-out");
	a_drain_bound: assert property ((r_r.st == ST_DRAIN) |-> ##[1:8] (r_r.st == ST_RESP))
		else $error("drain did not reach response");
	a_dequeue_head: assert property ((deq && !enq) |=> r_r.qcnt == $past(r_r.qcnt) - QCW'(1))
		else $error("matching reply did not dequeue");
	a_wrap_normal: assert property ((go && m_code == MSG_CFG && mfld == MODE_NORMAL
		&& r_r.mode[p] == MODE_WRAP) |=> (r_r.rcode == RC_INVALID && $stable(r_r.mode)))
		else $error("normal request left wrap");

endmodule // port_cfg_handler

`default_nettype wire

/* File: test/master_model.sv */
// Purpose: Far-side model counting responses and alerts from the handler
// Assumes: Response and alert strobes are one-cycle pulses
// Notes:   The bench builds the messages; this side only listens
`timescale 1ns/1ps
`default_nettype none
module master_model (
	input  wire logic        core_clk,
	input  wire logic        srst,
	input  wire logic        resp_valid,
	input  wire logic        alert_valid,
	input  wire logic [23:0] alert_code,
	output int               resp_cnt,
	output int               alert_cnt,
	output logic [23:0]      last_alert
);
	// Count every answer; the bench waits on these for responses, and on fixed cycle counts for alerts
	always_ff @(posedge core_clk) begin
		if (srst) begin
			resp_cnt   <= 0;
			alert_cnt  <= 0;
			last_alert <= 24'h000000;
		end else begin
			if (resp_valid) begin
				resp_cnt <= resp_cnt + 1;
			end
			if (alert_valid) begin
				alert_cnt  <= alert_cnt + 1;
				last_alert <= alert_code;
			end
		end
	end
endmodule // master_model
`default_nettype wire

/* File: test/tb_port_config_message_handler.sv */
// Purpose: Self-checking bench for the configuration message handler
// Assumes: Zero-wait APB slave, one message in flight
// Notes:   Long ack limit shortened to 50 cycles; port 1 lacks long reach
`timescale 1ns/1ps
`default_nettype none
module tb_port_config_message_handler
	import port_cfg_pkg::*;
;
	logic core_clk = 0, srst = 1, psel = 0, penable = 0, pwrite = 0, last_err;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, ret_path, rd;
	logic [1:0] port_operational = 2'h3, erp_invoke = 2'h0, query_clear_err = 2'h0;
	logic [1:0] user_char_enable, extended_distance_on, begin_comm;
	logic pready, pslverr, resp_valid, resp_port, alert_valid;
	logic alert_src_port, alert_tx_port, reflection_flag;
	logic [7:0] resp_code;
	logic [15:0] resp_tag, alert_tag, tg = 16'h1000, ok_tag;
	logic [23:0] alert_code, last_alert;
	logic [1:0][1:0] port_mode, negotiate_speed;
	logic [1:0][15:0] ack_limit;
	logic [1:0][7:0] a_quota, b_quota;
	logic [1:0] dual_spd = 2'h0, low_spd = 2'h0;
	int fail_count = 0, tests_run = 0, resp_cnt, alert_cnt, bc_seen = 0;

	// Speed status stays low until the slow-speed scenario at the end
	port_cfg_handler #(.ACK_LONG_CYC(16'h0032), .EXT_DIST_PORTS(2'h1),
		.ALERT_SLOW(24'h2A0000)) i_dut (
		.core_clk, .srst, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .prdata,
		.pslverr, .port_operational, .erp_invoke, .query_clear_err,
		.dual_speed_capable(dual_spd), .running_low_speed(low_spd), .resp_valid, .resp_code,
		.resp_tag, .resp_port, .ret_path, .alert_valid, .alert_code, .alert_tag,
		.alert_src_port, .alert_tx_port, .port_mode, .user_char_enable,
		.extended_distance_on, .ack_limit, .negotiate_speed, .a_quota, .b_quota,
		.reflection_flag, .begin_comm);
	master_model i_master (.core_clk, .srst, .resp_valid, .alert_valid, .alert_code,
		.resp_cnt, .alert_cnt, .last_alert);
	// Beginning communication pulses seen
	always @(posedge core_clk) if (begin_comm != 2'h0) bc_seen <= bc_seen + 1;

	// ----------------------------------------
	// Clock, watchdog, verdict
	// ----------------------------------------
	initial begin
		forever #4 core_clk = ~core_clk;
	end
	initial begin
		#400000;
		fail_count++;
		print_verdict();
	end
	task print_verdict;
		if (fail_count == 0 && tests_run > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			fail_count++;
			$display("BAD %0t got %h exp %h", $time, got, exp);
		end
	endtask

	// ----------------------------------------
	// Bus and message tasks
	// ----------------------------------------
	// Request held until pready is seen high at an edge
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge core_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		do begin
			@(posedge core_clk);
		end while (pready !== 1'b1);
		rd = prdata;
		last_err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic msg(input logic [127:0] m, input logic via);
		for (int i = 0; i < 4; i++) apb(1'b1, 8'(i * 4), m[127 - 32 * i -: 32]);
		apb(1'b1, OFF_CTRL, {30'h0, via, 1'b1});
	endtask
	// Fresh tag each time, first quota never zero from the caller; threshold 2
	task automatic cfg(input logic [7:0] p, input logic via, input logic [7:0] a, b, ctl,
			input logic [1:0] spd, input logic [7:0] rc);
		int base;
		base = resp_cnt;
		tg = tg + 16'h0001;
		msg({MSG_CFG, p, tg, 16'hBEEF, tg, 8'h00, a, b, ctl, 24'h000002, 6'h0, spd}, via);
		repeat (20) if (resp_cnt == base) @(posedge core_clk);
		#1;
		chk(resp_cnt, base + 1);
		chk(resp_code, rc);
		chk(resp_tag, tg);
		chk(resp_port, via);
		if (rc == RC_OK) ok_tag = tg;
	endtask
	task automatic reply(input logic [23:0] code, input logic [7:0] q);
		msg({MSG_REPLY, RC_OK, ok_tag, code, 72'h0}, 1'b1);
		repeat (3) @(posedge core_clk);
		apb(1'b0, OFF_STAT, 32'h0);
		chk(rd[7:0], q);
	endtask

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task t_valid;
		chk(ack_limit[0], ACK_SHORT_CYC);
		chk(a_quota[0], RST_QUOTA);
		cfg(8'h00, 1'b1, 8'h02, 8'h03, 8'hA0, 2'h1, RC_OK);
		chk(ret_path, {16'hBEEF, tg});
		chk(alert_tx_port, 1'b1);
		chk(user_char_enable[0], 1'b1);
		chk(b_quota[0], 8'h03);
		chk(port_mode[0], MODE_NORMAL);
		cfg(8'h00, 1'b1, 8'h02, 8'h03, 8'h20, 2'h0, RC_OK);
		chk(user_char_enable[0], 1'b0);
		chk(negotiate_speed[0], 2'h1);
	endtask
	task t_reject;
		cfg(8'h00, 1'b1, 8'h05, 8'h04, 8'h20, 2'h2, RC_INVALID);
		chk(a_quota[0], 8'h02);
		chk(negotiate_speed[0], 2'h1);
		apb(1'b0, 8'h40, 32'h0);
		chk(last_err, 1'b1);
	endtask
	task t_modes;
		cfg(8'h00, 1'b0, 8'h02, 8'h03, 8'h10, 2'h3, RC_INVALID);
		cfg(8'h00, 1'b1, 8'h02, 8'h03, 8'h10, 2'h3, RC_OK);
		chk(port_mode[0], MODE_WRAP);
		chk(negotiate_speed[0], 2'h3);
		cfg(8'h00, 1'b1, 8'h02, 8'h03, 8'h20, 2'h3, RC_INVALID);
		chk(port_mode[0], MODE_WRAP);
		cfg(8'h00, 1'b1, 8'h02, 8'h03, 8'h70, 2'h3, RC_OK);
		chk(port_mode[0], MODE_PRIV);
		chk(bc_seen, 1);
		chk(reflection_flag, 1'b1);
		port_operational <= 2'h1;
		cfg(8'h00, 1'b1, 8'h02, 8'h03, 8'h20, 2'h3, RC_OK);
		chk(reflection_flag, 1'b1);
		port_operational <= 2'h3;
		cfg(8'h00, 1'b1, 8'h02, 8'h03, 8'h20, 2'h3, RC_OK);
		chk(reflection_flag, 1'b0);
	endtask
	task t_ext;
		cfg(8'h00, 1'b1, 8'h02, 8'h03, 8'h22, 2'h0, RC_OK);
		chk(ack_limit[0], 16'h0032);
		chk(extended_distance_on[0], 1'b1);
		cfg(8'h00, 1'b1, 8'h02, 8'h03, 8'h23, 2'h0, RC_OK);
		chk(ack_limit[0], ACK_SHORT_CYC);
		cfg(8'h01, 1'b0, 8'h02, 8'h03, 8'h22, 2'h0, RC_INVALID);
	endtask
	task t_queue;
		apb(1'b1, OFF_ENQ, {8'h00, 24'h123456});
		repeat (10) @(posedge core_clk);
		chk(last_alert, 24'h123456);
		chk(alert_tag, ok_tag);
		reply(24'h223456, 8'h01);
		reply(24'h123456, 8'h00);
		repeat (4) @(posedge core_clk) erp_invoke <= ~erp_invoke & 2'h1;
		repeat (10) @(posedge core_clk);
		chk(last_alert, ALERT_ALARM);
		reply(ALERT_ALARM, 8'h00);
		repeat (2) @(posedge core_clk) erp_invoke <= ~erp_invoke & 2'h1;
		repeat (10) @(posedge core_clk);
		chk(alert_cnt, 2);
		@(posedge core_clk) query_clear_err <= 2'h1;
		@(posedge core_clk) query_clear_err <= 2'h0;
		repeat (4) @(posedge core_clk) erp_invoke <= ~erp_invoke & 2'h1;
		repeat (10) @(posedge core_clk);
		chk(alert_cnt, 3);
		reply(ALERT_ALARM, 8'h00);
		dual_spd <= 2'h1;
		low_spd <= 2'h1;
		cfg(8'h00, 1'b1, 8'h02, 8'h03, 8'h20, 2'h0, RC_OK);
		repeat (10) @(posedge core_clk);
		chk(last_alert, 24'h2A0000);
		dual_spd <= 2'h0;
		cfg(8'h00, 1'b1, 8'h02, 8'h03, 8'h00, 2'h0, RC_OK);
		chk(alert_cnt, 5);
		chk(alert_src_port, 1'b0);
	endtask

	// Main sequence
	initial begin
		repeat (6) @(posedge core_clk);
		srst <= 1'b0;
		t_valid();
		t_reject();
		t_modes();
		t_ext();
		t_queue();
		print_verdict();
	end
endmodule // tb_port_config_message_handler
`default_nettype wire
